// File: include/owp_pkg.sv
// package: constants for the one-wire rgb pwm driver
package owp_pkg;
  localparam int             SHIFT_W       = 48;
  localparam int             GS_W          = 12;
  localparam int             LATCH_W       = 36;
  localparam logic [11:0]    WRITE_KEY     = 12'h3aa;
  localparam int             KEY_LSB       = 36;
  localparam int             CH0_LSB       = 24;
  localparam int             CH1_LSB       = 12;
  localparam int             CH2_LSB       = 0;
  localparam int             SYS_MHZ       = 100;
  localparam int             COUNT_MHZ     = 12;
  // count clock divider, rounded down so the count clock is never slower
  localparam int             COUNT_DIV     = SYS_MHZ / COUNT_MHZ;
  localparam int             PERIOD_W      = 16;
  localparam logic [15:0]    PERIOD_MAX    = 16'hffff;
  localparam int             ZERO_NUM      = 9;
  localparam int             ZERO_DEN      = 10;
  localparam int             EOP_PERIODS   = 4;
  localparam int             LATCH_PERIODS = 8;
  typedef enum logic [1:0] {
    OWP_MEASURE1 = 2'b00,
    OWP_MEASURE2 = 2'b01,
    OWP_BIT      = 2'b11,
    OWP_FORWARD  = 2'b10
  } owp_state_t;
endpackage

// File: include/owp_pwm_if.sv
// interface: latched levels and latch strobe into the pwm engine
`timescale 1ns/1ps
`default_nettype none
interface owp_pwm_if;
  logic [owp_pkg::LATCH_W-1:0] levels;
  logic                        load;
  logic [2:0]                  sink_on;
  modport ctrl (output levels, output load, input sink_on);
  modport pwm (input levels, input load, output sink_on);
endinterface
`default_nettype wire

// File: core/owp_pwm.sv
// module: 12-bit pwm engine on an internal count clock tick
`timescale 1ns/1ps
`default_nettype none
module owp_pwm #(
  parameter int DIV = owp_pkg::COUNT_DIV
) (
  input wire logic clk,
  input wire logic rst,
  owp_pwm_if.pwm   bus
);
  logic [7:0]                  div;
  logic [7:0]                  next_div;
  logic [11:0]                 cnt;
  logic [11:0]                 next_cnt;
  logic [owp_pkg::LATCH_W-1:0] gs;
  logic [owp_pkg::LATCH_W-1:0] next_gs;
  logic [2:0]                  on;
  logic [2:0]                  next_on;
  logic                        tick;

  assign bus.sink_on = on;

  // tick generator, restarted at each latch load, stands in for the internal oscillator
  always_comb begin
    tick     = (div == 8'(DIV - 1));
    next_div = tick ? 8'h00 : div + 8'h01;
    next_cnt = cnt;
    next_gs  = gs;
    next_on  = on;
    if (bus.load) begin
      next_gs  = bus.levels;
      next_cnt = 12'h000;
      next_on  = 3'h0;
      next_div = 8'h00;
    end else if (tick) begin
      next_cnt = cnt + 12'h001;
      for (int c = 0; c < 3; c++) begin
        // on from count one while count <= level; level zero never lights
        next_on[c] = (next_cnt != 12'h000) && (gs[c*12 +: 12] != 12'h000)
                     && (next_cnt <= gs[c*12 +: 12]);
      end
    end
  end

  // channel c of levels: 0 = ch2, 1 = ch1, 2 = ch0 (register order)
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div <= 8'h00;
      cnt <= 12'h000;
      gs  <= '0;
      on  <= 3'h0;
    end else begin
      div <= next_div;
      cnt <= next_cnt;
      gs  <= next_gs;
      on  <= next_on;
    end
  end

  on_tracks_level_a: assert property (@(posedge clk) disable iff (rst)
    tick && !bus.load |=> on[0] == ((cnt != 12'h000) && (gs[11:0] != 12'h000) && (cnt <= gs[11:0])))
    else $error("sink output does not follow count against level");
  load_clears_a: assert property (@(posedge clk) disable iff (rst)
    bus.load |=> (cnt == 12'h000) && (on == 3'h0))
    else $error("latch load did not clear counter and outputs");
  count_steps_a: assert property (@(posedge clk) disable iff (rst)
    tick && !bus.load |=> cnt == $past(cnt) + 12'h001)
    else $error("counter did not advance on tick");
endmodule
`default_nettype wire

// File: core/owp_driver.sv
// module: one-wire self-timed receiver, forwarder and rgb pwm driver top
//
// Function
// - outputs off after reset until nonzero levels are latched
// - output on while count between one and latched level; zero never lights
// - first-to-second rising edge sets bit period, after reset and each latch gap
// - period measurement shifts two zero bits into the register
// - no second edge before 0.9 period decodes a zero
// - second edge before half period decodes a one
// - packet-end hold freezes shift register and forwards the line
// - latch hold copies levels into display latch, pwm restarts
// - latch copies only when key equals 3aah
// - latch load resets counter and forces outputs off
// - bits 0-11 ch2, 12-23 ch1, 24-35 ch0, 36-47 key
// - counter advances on a ~12 MHz internal tick that each latch load restarts
`timescale 1ns/1ps
`default_nettype none
module owp_driver #(
  parameter int EOP_PERIODS   = owp_pkg::EOP_PERIODS,
  parameter int LATCH_PERIODS = owp_pkg::LATCH_PERIODS
) (
  // clock and reset
  input  wire logic       CLK_SYS,
  input  wire logic       SYS_RST,
  // serial link
  input  wire logic       SERIAL_LINE_IN,
  output var  logic       SERIAL_LINE_OUT,
  // led sinks, high = sinking
  output var  logic [2:0] LED_SINK_OUTPUT
);
  localparam int PW = owp_pkg::PERIOD_W;
  localparam int LW = PW + 4;

  ////////////////////////////////////////////////////////////////////////////
  // state
  owp_pkg::owp_state_t               st;
  owp_pkg::owp_state_t               next_st;
  logic [PW-1:0]                     period;
  logic [PW-1:0]                     next_period;
  logic [LW-1:0]                     timer;
  logic [LW-1:0]                     next_timer;
  logic [LW-1:0]                     low_cnt;
  logic [LW-1:0]                     next_low_cnt;
  logic [owp_pkg::SHIFT_W-1:0]       shreg;
  logic [owp_pkg::SHIFT_W-1:0]       next_shreg;
  logic [owp_pkg::LATCH_W-1:0]       levels;
  logic [owp_pkg::LATCH_W-1:0]       next_levels;
  logic                              load;
  logic                              next_load;
  logic                              prev_in;
  logic                              sout;
  logic                              next_sout;
  logic                              second_edge;
  logic                              next_second_edge;
  logic                              rise;
  logic                              eop_hit;
  logic                              latch_hit;
  logic [LW-1:0]                     zero_lim;
  logic [LW-1:0]                     one_lim;
  logic [LW-1:0]                     eop_lim;
  logic [LW-1:0]                     latch_lim;

  owp_pwm_if                         pwm_bus ();

  assign pwm_bus.levels = levels;
  assign pwm_bus.load   = load;

  // thresholds derived from measured period; latch must exceed packet end
  always_comb begin
    one_lim   = LW'({period, 4'h0} >> 5); // half period
    zero_lim  = LW'((32'(period) * owp_pkg::ZERO_NUM) / owp_pkg::ZERO_DEN);
    eop_lim   = LW'(32'(period) * EOP_PERIODS);
    latch_lim = LW'(32'(period) * LATCH_PERIODS);
  end

  assign rise      = SERIAL_LINE_IN && !prev_in;
  assign eop_hit   = !SERIAL_LINE_IN && (low_cnt >= eop_lim);
  assign latch_hit = !SERIAL_LINE_IN && (low_cnt >= latch_lim);

  ////////////////////////////////////////////////////////////////////////////
  // receiver next-state logic
  // inputs are taken as already synchronous, so edges are found directly
  always_comb begin
    next_st          = st;
    next_period      = period;
    next_timer       = (timer == '1) ? timer : timer + LW'(1);
    next_low_cnt     = SERIAL_LINE_IN ? '0 : ((low_cnt == '1) ? low_cnt : low_cnt + LW'(1));
    next_shreg       = shreg;
    next_levels      = levels;
    next_load        = 1'b0;
    next_sout        = 1'b0;
    next_second_edge = second_edge;
    case (st)
      owp_pkg::OWP_MEASURE1: begin
        if (rise) begin
          next_timer = LW'(1);
          next_st    = owp_pkg::OWP_MEASURE2;
        end
      end
      owp_pkg::OWP_MEASURE2: begin
        if (rise) begin
          // saturate so an over-slow host still gets a finite period
          next_period = (timer > LW'(owp_pkg::PERIOD_MAX)) ? owp_pkg::PERIOD_MAX
                                                           : timer[PW-1:0];
          next_shreg  = {shreg[owp_pkg::SHIFT_W-3:0], 2'b00};
          next_timer  = LW'(1);
          // this rise opens the second timing slot, already counted as a zero
          next_second_edge = 1'b1;
          next_st     = owp_pkg::OWP_BIT;
        end
      end
      owp_pkg::OWP_BIT: begin
        if (rise && !second_edge && (timer < one_lim)) begin
          next_shreg       = {shreg[owp_pkg::SHIFT_W-2:0], 1'b1};
          next_second_edge = 1'b1;
        end else if (rise) begin
          next_timer       = LW'(1);
          next_second_edge = 1'b0;
        end else if (!second_edge && timer == zero_lim) begin
          next_shreg       = {shreg[owp_pkg::SHIFT_W-2:0], 1'b0};
          next_second_edge = 1'b1;
        end
        if (eop_hit) begin
          next_st = owp_pkg::OWP_FORWARD;
        end
      end
      owp_pkg::OWP_FORWARD: begin
        next_sout = SERIAL_LINE_IN;
      end
      default: begin
        next_st = owp_pkg::OWP_MEASURE1;
      end
    endcase
    // latch gap in bit or forward state overrides next state and line output, then period is re-measured
    if (latch_hit && (st == owp_pkg::OWP_FORWARD || st == owp_pkg::OWP_BIT)) begin
      if (shreg[owp_pkg::SHIFT_W-1:owp_pkg::KEY_LSB] == owp_pkg::WRITE_KEY) begin
        next_levels = shreg[owp_pkg::LATCH_W-1:0];
        next_load   = 1'b1;
      end
      next_st   = owp_pkg::OWP_MEASURE1;
      next_sout = 1'b0;
    end
  end

  // receiver registers
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      st          <= owp_pkg::OWP_MEASURE1;
      period      <= owp_pkg::PERIOD_MAX;
      timer       <= '0;
      low_cnt     <= '0;
      shreg       <= '0;
      levels      <= '0;
      load        <= 1'b0;
      prev_in     <= 1'b0;
      sout        <= 1'b0;
      second_edge <= 1'b0;
    end else begin
      st          <= next_st;
      period      <= next_period;
      timer       <= next_timer;
      low_cnt     <= next_low_cnt;
      shreg       <= next_shreg;
      levels      <= next_levels;
      load        <= next_load;
      prev_in     <= SERIAL_LINE_IN;
      sout        <= next_sout;
      second_edge <= next_second_edge;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pwm engine and outputs
  owp_pwm u_pwm (
    .clk (CLK_SYS),
    .rst (SYS_RST),
    .bus (pwm_bus)
  );

  // register order puts ch0 highest; pins are ch0..ch2 at bits 0..2
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      LED_SINK_OUTPUT <= 3'h0;
      SERIAL_LINE_OUT <= 1'b0;
    end else begin
      LED_SINK_OUTPUT <= {pwm_bus.sink_on[0], pwm_bus.sink_on[1], pwm_bus.sink_on[2]};
      SERIAL_LINE_OUT <= sout;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence measure_pair_s;
    st == owp_pkg::OWP_MEASURE2 && rise;
  endsequence
  measure_zeros_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    measure_pair_s |=> shreg[1:0] == 2'b00 && st == owp_pkg::OWP_BIT)
    else $error("period measurement did not shift two zeros");
  period_store_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (measure_pair_s and (timer <= LW'(owp_pkg::PERIOD_MAX))) |=> period == $past(timer[PW-1:0]))
    else $error("bit period not stored");
  key_gate_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    load |-> $past(shreg[47:36]) == owp_pkg::WRITE_KEY)
    else $error("latch loaded with wrong key");
  latch_copy_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    load |-> levels == $past(shreg[35:0]))
    else $error("latch contents differ from register");
  forward_freeze_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    st == owp_pkg::OWP_FORWARD && !latch_hit |=> $stable(shreg))
    else $error("register moved while forwarding");
  forward_follow_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    st == owp_pkg::OWP_FORWARD && !latch_hit |=> ##1 SERIAL_LINE_OUT == $past(SERIAL_LINE_IN, 2))
    else $error("line not forwarded");
  one_bit_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    st == owp_pkg::OWP_BIT && rise && !second_edge && timer < one_lim |=> shreg[0])
    else $error("early second edge not decoded as one");
  reset_dark_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    levels == '0 |=> ##2 LED_SINK_OUTPUT == 3'h0)
    else $error("output lit with zero levels");
endmodule
`default_nettype wire

// File: bench/owp_host.sv
// partner model: host controller driving the one-wire serial line
`timescale 1ns/1ps
`default_nettype none
module owp_host (
  // clock
  input  wire logic clk,
  // serial line to the device
  output var  logic line
);
  // line idles low; the host drives it at all times, so it never floats
  initial line = 1'b0;
  //////////////////////////////////////////////////////////////////////
  // let n falling edges pass
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one bit slot of p cycles; narrow pulses keep every rise distinct
  task automatic send_bit(input logic b, input int p);
    line = 1'b1;
    idle(p / 8);
    line = 1'b0;
    if (b) begin // second rise at a quarter period
      idle(p / 4 - p / 8);
      line = 1'b1;
      idle(p / 8);
      line = 1'b0;
      idle(p - p / 4 - p / 8);
    end else begin
      idle(p - p / 8);
    end
  endtask
  // timing pair, then the low 46 bits of the word, msb first
  task automatic send_packet(input logic [47:0] w, input int p);
    send_bit(1'b0, p);
    send_bit(1'b0, p);
    for (int i = 45; i >= 0; i--) begin
      send_bit(w[i], p);
    end
  endtask
endmodule
`default_nettype wire

// File: bench/tb.sv
// testbench: one-wire rgb pwm driver against the host model
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int          WIN   = 2400;  // longer than any on-time used here
  localparam int          LIMIT = 80000; // about twice the planned run
  localparam int          LAT   = owp_pkg::LATCH_PERIODS;
  localparam int          EOP   = owp_pkg::EOP_PERIODS;
  localparam logic [47:0] W1    = {12'h3aa, 12'h003, 12'h006, 12'h009};
  localparam logic [47:0] W2    = {12'h3aa, 12'h0ff, 12'h0ff, 12'h0ff};
  localparam logic [47:0] W3    = {12'h3aa, 12'h0c8, 12'h0c8, 12'h0c8};
  localparam logic [47:0] W4    = {12'h3aa, 12'h004, 12'h020, 12'h001};
  logic        clk_sys;
  logic        sys_rst;
  logic        serial_in;
  logic        serial_out;
  logic [2:0]  led;
  logic [1:0]  hist;
  logic        measuring;
  logic        fwd_on;
  logic        fwd_off;
  int          on_cnt [3];
  int          bad;
  int          cycles;
  int          miscompares;
  int          total_checks;
  logic [47:0] row_word [4];
  int          row_p [4];

  owp_driver #(.EOP_PERIODS(EOP), .LATCH_PERIODS(LAT)) owp_driver_inst (
    .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .SERIAL_LINE_IN(serial_in),
    .SERIAL_LINE_OUT(serial_out), .LED_SINK_OUTPUT(led));
  owp_host owp_host_inst (.clk(clk_sys), .line(serial_in));
  //////////////////////////////////////////////////////////////////////
  // system clock, 10 ns
  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  // on-time counting, forwarded line watch and hang guard
  always @(posedge clk_sys) begin
    cycles++;
    for (int k = 0; k < 3; k++) begin
      if (measuring && led[k] === 1'b1) on_cnt[k]++;
      // the very first edge may still see the value from before reset took hold
      if (cycles > 1 && led[k] !== 1'b0 && led[k] !== 1'b1) bad++;
    end
    if (fwd_on && serial_out !== hist[1]) bad++;
    if (fwd_off && serial_out !== 1'b0) bad++;
    hist <= {hist[0], serial_in};
    if (cycles == LIMIT) begin
      miscompares++;
      $display("wrong value at %0t: run did not finish", $time);
      stop_test();
    end
  end
  //////////////////////////////////////////////////////////////////////
  // on-cycles per channel; one tick per count, zero level never lights
  function automatic int exp_on(input logic [47:0] w, input int k);
    int lsb;
    lsb = (k == 0) ? owp_pkg::CH0_LSB : (k == 1) ? owp_pkg::CH1_LSB : owp_pkg::CH2_LSB;
    return (w[47:36] === owp_pkg::WRITE_KEY) ? owp_pkg::COUNT_DIV * int'(w[lsb +: 12]) : 0;
  endfunction

  task automatic check(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      miscompares++;
      $display("wrong value at %0t: got %0d, expected %0d", $time, got, exp);
    end
  endtask

  task automatic measure(input int n);
    on_cnt = '{0, 0, 0};
    measuring = 1'b1;
    repeat (n) @(negedge clk_sys);
    measuring = 0;
  endtask

  // send one packet, then count on-time from the packet end through the latch gap and load
  task automatic load(input logic [47:0] w, input int p);
    owp_host_inst.send_packet(w, p);
    measure((LAT + 1) * p + WIN);
    for (int k = 0; k < 3; k++) check(on_cnt[k], exp_on(w, k));
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    sys_rst = 1'b1;
    {measuring, fwd_on, fwd_off, hist} = 5'h00;
    bad = 0;
    cycles = 0;
    miscompares = 0;
    total_checks = 0;
    on_cnt = '{0, 0, 0};
    row_word = '{{12'h3aa, 12'h005, 12'h000, 12'h011}, {12'h3aa, 12'h001, 12'h002, 12'h003},
                 {12'h1aa, 12'h009, 12'h009, 12'h009}, {12'h3aa, 12'h0c8, 12'h064, 12'h0fa}};
    row_p = '{40, 33, 40, 100};
    repeat (3) @(negedge clk_sys);
    sys_rst = 1'b0;
    // nothing latched yet, so the sinks stay dark
    measure(300);
    for (int k = 0; k < 3; k++) check(on_cnt[k], 0);
    $display("test power-up done");
    // table rows; a refused key leaves the counter past every level, so all stay dark
    for (int r = 0; r < 4; r++) load(row_word[r], row_p[r]);
    $display("test table done");
    // cascade: the second packet passes through, only the first is kept
    fwd_off = 1'b1;
    owp_host_inst.send_packet(W1, 40);
    fwd_off = 1'b0;
    owp_host_inst.idle((EOP + 1) * 40);
    fwd_on = 1'b1;
    owp_host_inst.send_packet(W2, 40);
    fwd_on = 1'b0;
    measure((LAT + 1) * 40 + WIN);
    for (int k = 0; k < 3; k++) check(on_cnt[k], exp_on(W1, k));
    $display("test cascade done");
    // reset while the sinks are lit: they go dark and stay dark
    owp_host_inst.send_packet(W3, 40);
    owp_host_inst.idle((LAT + 1) * 40);
    sys_rst = 1'b1;
    repeat (3) @(negedge clk_sys);
    sys_rst = 1'b0;
    measure(WIN);
    for (int k = 0; k < 3; k++) check(on_cnt[k], 0);
    // period measured afresh after reset at a new rate
    load(W4, 50);
    check(bad, 0);
    $display("test reset done");
    stop_test();
  end
endmodule
`default_nettype wire
